// ---- core/cnec_node.sv ----
// CAN node error-state, bus-off recovery, time stamp and disable handling.
// Assumes bit-level events (bit end, idle seen, error increments) come from the
// protocol engine as one-cycle pulses synchronous to clk_i.
// The transmit glitch on a short module disable is kept on purpose, to match the part.
// The time stamp wraps at its width; both error counters saturate instead of wrapping.
// Notes on behaviour
// - A disable request raised and dropped within a bit time may give a dominant pulse.
// - The time stamp counts actual bit times, resynchronised lengths included.
// - Reaching the warning level sets the warning flag and pulses the warning interrupt.
// - Transmit counter above 255 enters bus-off and loads both counters with one.
// - Entering bus-off sets the hold bit and pulses the bus-off interrupt.
// - Recovery starts on its own once bus-off is entered.
// - During recovery each idle time seen increments the receive counter.
// - Receive counter at 0x60 in recovery shows warning plus bus-off and pulses its interrupt.
// - After 128 idle times recovery ends, flags clear, alert is set, hold stays set.
// - Setting node disable waits for bus idle and then sets suspend acknowledge.
// - Suspend acknowledge is an indication only and steers nothing else.
`timescale 1ns/1ns
`default_nettype none
module cnec_node
    import cnec_pkg::*;
#(
    parameter int TS_W = CNEC_TS_W
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic module_disable_request_i,
    input wire logic node_disable_bit_i,
    input wire logic hold_set_i,
    input wire logic hold_clr_i,
    input wire logic [8:0] warn_level_i,
    input wire logic bit_end_i,
    input wire logic bus_idle_i,
    input wire logic idle_seen_i,
    input wire logic tec_inc_i,
    input wire logic tec_dec_i,
    input wire logic rec_inc_i,
    input wire logic rec_dec_i,
    input wire logic [3:0] err_step_i,
    input wire logic alert_clr_i,
    input wire logic tx_req_i,
    output logic txd_o,
    output logic [8:0] rec_o,
    output logic [8:0] tec_o,
    output logic error_warning_flag_o,
    output logic bus_off_flag_o,
    output logic hold_o,
    output logic alert_o,
    output logic suspend_acknowledge_o,
    output logic warn_irq_o,
    output logic bus_off_flag_irq_o,
    output logic prewarn_irq_o,
    output logic [TS_W-1:0] time_stamp_o
);
    cnec_state_e state, next_state;
    logic [8:0] rec, next_rec;
    logic [8:0] tec, next_tec;
    logic [7:0] idle_cnt, next_idle_cnt;
    logic error_warning_flag, next_error_warning_flag;
    logic bus_off_flag, next_bus_off_flag;
    logic hold, next_hold;
    logic alert, next_alert;
    logic suspend_acknowledge, next_suspend_acknowledge;
    logic warn_irq, next_warn_irq;
    logic bus_off_flag_irq, next_bus_off_flag_irq;
    logic pre_irq, next_pre_irq;
    logic txd, next_txd;
    logic [TS_W-1:0] ts, next_ts;
    logic [9:0] tec_sum;
    // One-cycle events from the error state that the hold and alert groups act on
    logic bus_off_flag_entry, rec_done;

    assign tec_sum = {1'b0, tec} + {6'h00, err_step_i};

    always_comb begin
        next_state = state;
        next_rec = rec;
        next_tec = tec;
        next_idle_cnt = idle_cnt;
        next_error_warning_flag = error_warning_flag;
        next_bus_off_flag = bus_off_flag;
        next_warn_irq = 1'b0;
        next_bus_off_flag_irq = 1'b0;
        next_pre_irq = 1'b0;
        bus_off_flag_entry = 1'b0;
        rec_done = 1'b0;
        case (state)
            CNEC_ACTIVE: begin
                // Saturate so a large step cannot wrap back under the bus-off limit
                if (tec_inc_i && !hold) begin
                    next_tec = tec_sum[9] ? 9'h1ff : tec_sum[8:0];
                end else if (tec_dec_i && tec != 9'h000) begin
                    next_tec = tec - 9'h001;
                end
                // Receive counter stops at its top instead of wrapping
                if (rec_inc_i && !hold && rec != 9'h1ff) begin
                    next_rec = rec + 9'h001;
                end else if (rec_dec_i && rec != 9'h000) begin
                    next_rec = rec - 9'h001;
                end
                if (!error_warning_flag && (next_tec >= warn_level_i || next_rec >= warn_level_i)) begin
                    next_error_warning_flag = 1'b1;
                    next_warn_irq = 1'b1;
                end else if (next_tec < warn_level_i && next_rec < warn_level_i) begin
                    // Warning drops only once both counters are back under the level
                    next_error_warning_flag = 1'b0;
                end
                if (next_tec > CNEC_TEC_LIMIT) begin
                    next_rec = CNEC_BUS_OFF_FLAG_LOAD;
                    next_tec = CNEC_BUS_OFF_FLAG_LOAD;
                    next_bus_off_flag = 1'b1;
                    bus_off_flag_entry = 1'b1;
                    next_bus_off_flag_irq = 1'b1;
                    next_idle_cnt = 8'h00;
                    next_state = CNEC_BUSOFF;
                end
            end
            CNEC_BUSOFF: begin
                // Off the bus only idle times move the counters; errors are ignored
                // idle increments
                if (idle_seen_i) begin
                    next_rec = rec + 9'h001;
                    next_idle_cnt = idle_cnt + 8'h01;
                    if (next_rec == CNEC_PREWARN) begin
                        next_error_warning_flag = 1'b1;
                        next_pre_irq = 1'b1;
                    end
                    if (next_idle_cnt == CNEC_IDLE_CNT) begin
                        next_error_warning_flag = 1'b0;
                        next_bus_off_flag = 1'b0;
                        rec_done = 1'b1;
                        next_rec = 9'h000;
                        next_tec = 9'h000;
                        next_state = CNEC_ACTIVE;
                    end
                end
            end
            // Unused encodings fall back to the active state
            default: next_state = CNEC_ACTIVE;
        endcase
    end

    // bit-time stamp
    // Each bit end from the engine counts once, whatever its resynchronised length
    always_comb begin
        next_ts = ts;
        if (bit_end_i) begin
            next_ts = ts + 1'b1;
        end
    end

    // Hold group: a software set and a bus-off entry both win over a clear
    always_comb begin
        next_hold = hold;
        if (hold_set_i || bus_off_flag_entry) begin
            next_hold = 1'b1;
        end else if (hold_clr_i) begin
            next_hold = 1'b0;
        end
    end

    // Alert group: recovery end wins over a clear in the same cycle
    always_comb begin
        next_alert = alert;
        if (rec_done) begin
            next_alert = 1'b1;
        end else if (alert_clr_i) begin
            next_alert = 1'b0;
        end
    end

    // The glitch is reproduced so software meets the same hazard as on the part;
    // holding the node is the only guard against it
    always_comb begin
        next_txd = 1'b1;
        if (module_disable_request_i && !hold) begin
            next_txd = 1'b0;
        end else if (tx_req_i && !hold && !bus_off_flag && !node_disable_bit_i) begin
            // Ordinary dominant bits only while released, on the bus and enabled
            next_txd = 1'b0;
        end
    end

    // Acknowledge drops as soon as the disable bit is withdrawn
    always_comb begin
        next_suspend_acknowledge = suspend_acknowledge;
        if (!node_disable_bit_i) begin
            next_suspend_acknowledge = 1'b0;
        end else if (bus_idle_i) begin
            next_suspend_acknowledge = 1'b1;
        end
    end

    // Error state group: counters, recovery progress and status flags
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state <= CNEC_ACTIVE;
            rec <= 9'h000;
            tec <= 9'h000;
            idle_cnt <= 8'h00;
            error_warning_flag <= 1'b0;
            bus_off_flag <= 1'b0;
        end else begin
            state <= next_state;
            rec <= next_rec;
            tec <= next_tec;
            idle_cnt <= next_idle_cnt;
            error_warning_flag <= next_error_warning_flag;
            bus_off_flag <= next_bus_off_flag;
        end
    end

    // Interrupt pulses last exactly one cycle
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            warn_irq <= 1'b0;
            bus_off_flag_irq <= 1'b0;
            pre_irq <= 1'b0;
        end else begin
            warn_irq <= next_warn_irq;
            bus_off_flag_irq <= next_bus_off_flag_irq;
            pre_irq <= next_pre_irq;
        end
    end

    // Node starts held so nothing reaches the bus before software is ready
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            hold <= 1'b1;
        end else begin
            hold <= next_hold;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            alert <= 1'b0;
        end else begin
            alert <= next_alert;
        end
    end

    // Transmit line idles recessive
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            txd <= 1'b1;
        end else begin
            txd <= next_txd;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            suspend_acknowledge <= 1'b0;
        end else begin
            suspend_acknowledge <= next_suspend_acknowledge;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ts <= '0;
        end else begin
            ts <= next_ts;
        end
    end

    // Every output comes straight from a flip-flop
    assign txd_o = txd;
    assign rec_o = rec;
    assign tec_o = tec;
    assign error_warning_flag_o = error_warning_flag;
    assign bus_off_flag_o = bus_off_flag;
    assign hold_o = hold;
    assign alert_o = alert;
    assign suspend_acknowledge_o = suspend_acknowledge;
    assign warn_irq_o = warn_irq;
    assign bus_off_flag_irq_o = bus_off_flag_irq;
    assign prewarn_irq_o = pre_irq;
    assign time_stamp_o = ts;
endmodule // cnec_node
`default_nettype wire

// ---- core/cnec_pkg.sv ----
// Package for the CAN node error-state and bus-off control block.
// Assumes a single 100 MHz clock domain and plain control/status ports.
package cnec_pkg;
    localparam int CNEC_CNT_W = 9;
    localparam logic [8:0] CNEC_EWL_RST = 9'h060;
    localparam logic [8:0] CNEC_TEC_LIMIT = 9'h0ff;
    localparam logic [8:0] CNEC_BUS_OFF_FLAG_LOAD = 9'h001;
    localparam logic [7:0] CNEC_IDLE_CNT = 8'h80;
    localparam logic [8:0] CNEC_PREWARN = 9'h060;
    localparam int CNEC_TS_W = 16;
    typedef enum logic [1:0] {
        CNEC_ACTIVE,
        CNEC_BUSOFF
    } cnec_state_e;
endpackage

// ---- test/cnec_bus_model.sv ----
// Other nodes on the bus: bit ends of uneven length, idle times when quiet.
// Free running from time zero.
`timescale 1ns/1ns
`default_nettype none
module cnec_bus_model (
    input wire logic clk_i,
    input wire logic idle_i,
    output logic bit_end_o,
    output logic idle_seen_o
);
    logic [2:0] cnt = 3'h0;
    always_ff @(posedge clk_i) cnt <= (cnt == 3'h5) ? 3'h0 : cnt + 3'h1;
    assign bit_end_o = cnt == 3'h1 || cnt == 3'h5;
    assign idle_seen_o = idle_i && bit_end_o;
endmodule // cnec_bus_model
`default_nettype wire

// ---- test/cnec_node_checker.sv ----
// Assertion checker for the CAN node error and bus-off block.
// Bound into every cnec_node; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module cnec_node_checker #(
    parameter int TS_W = 16
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic bit_end_i,
    input wire logic idle_seen_i,
    input wire logic [8:0] rec_o,
    input wire logic [8:0] tec_o,
    input wire logic error_warning_flag_o,
    input wire logic bus_off_flag_o,
    input wire logic hold_o,
    input wire logic alert_o,
    input wire logic warn_irq_o,
    input wire logic bus_off_flag_irq_o,
    input wire logic prewarn_irq_o,
    input wire logic [TS_W-1:0] time_stamp_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    property p_ld; $rose(bus_off_flag_o) |-> rec_o == 9'h1 && tec_o == 9'h1; endproperty
    a_ld: assert property (p_ld) else $error("bus-off load");
    property p_bo; $rose(bus_off_flag_o) |-> hold_o && bus_off_flag_irq_o; endproperty
    a_bo: assert property (p_bo) else $error("bus-off entry");
    property p_st; bus_off_flag_o && !idle_seen_i |=> bus_off_flag_o && $stable(rec_o); endproperty
    a_st: assert property (p_st) else $error("recovery left");
    property p_in; bus_off_flag_o && idle_seen_i && rec_o < 9'h80 |=> rec_o == $past(rec_o) + 9'h1;
    endproperty
    a_in: assert property (p_in) else $error("idle count");
    property p_pw; bus_off_flag_o && idle_seen_i && rec_o == 9'h5f |=>
        error_warning_flag_o && prewarn_irq_o; endproperty
    a_pw: assert property (p_pw) else $error("prewarn");
    property p_en; bus_off_flag_o && idle_seen_i && rec_o == 9'h80 |=>
        !bus_off_flag_o && !error_warning_flag_o && alert_o && hold_o; endproperty
    a_en: assert property (p_en) else $error("recovery end");
    property p_wn; $rose(error_warning_flag_o) && !bus_off_flag_o |-> warn_irq_o; endproperty
    a_wn: assert property (p_wn) else $error("warning");
    property p_ts; 1'b1 |=> time_stamp_o == $past(time_stamp_o) + TS_W'($past(bit_end_i));
    endproperty
    a_ts: assert property (p_ts) else $error("time stamp");
endmodule // cnec_node_checker
bind cnec_node cnec_node_checker #(.TS_W(TS_W)) cnec_node_checker_inst (.*);
`default_nettype wire

// ---- test/cnec_node_test.sv ----
// Bench for the CAN node error block; inputs move 1 ns after each edge.
`timescale 1ns/1ns
`default_nettype none
`define CK(a, e) \
    begin \
        compares++; \
        if ((a) !== (e)) begin \
            errors++; \
            $display("BAD %0t got %h exp %h", $time, a, e); \
        end \
    end
module cnec_node_test;
    logic clk_i = 0, nrst_i = 0, mdr = 0, nd = 0, hc = 0, ti = 0, ac = 0, idle = 0;
    logic hs = 0, tq = 0;
    logic be, sn, txd, ewf, bof, hold, alert, sus;
    logic [8:0] rec, tec;
    logic [15:0] ts;
    logic [15:0] nbit = 0;
    int errors = 0, compares = 0, nidle = 0, k;
    always #5 clk_i = !clk_i;
    always @(posedge clk_i) begin
        nbit <= nrst_i ? nbit + 16'(be) : 16'h0;
        if (sn && bof) nidle <= nidle + 1;
    end
    cnec_bus_model cnec_bus_model_inst (.clk_i(clk_i), .idle_i(idle), .bit_end_o(be),
        .idle_seen_o(sn));
    cnec_node cnec_node_inst (.clk_i(clk_i), .nrst_i(nrst_i), .module_disable_request_i(mdr),
        .node_disable_bit_i(nd), .hold_set_i(hs), .hold_clr_i(hc), .warn_level_i(9'h060),
        .bit_end_i(be), .bus_idle_i(idle), .idle_seen_i(sn), .tec_inc_i(ti), .tec_dec_i(1'b0),
        .rec_inc_i(1'b0), .rec_dec_i(1'b0), .err_step_i(4'h8), .alert_clr_i(ac), .tx_req_i(tq),
        .txd_o(txd), .rec_o(rec), .tec_o(tec), .error_warning_flag_o(ewf), .bus_off_flag_o(bof),
        .hold_o(hold), .alert_o(alert), .suspend_acknowledge_o(sus), .warn_irq_o(),
        .bus_off_flag_irq_o(), .prewarn_irq_o(), .time_stamp_o(ts));
    task tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task end_of_test;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task wait_rec(input logic [8:0] v);
        for (k = 0; k < 3000 && rec !== v; k++) tick(1);
        if (rec !== v) begin
            errors++;
            end_of_test;
        end
    endtask
    initial begin
        tick(20);
        nrst_i = 1;
        tick(1);
        `CK({hold, txd, bof, ewf, alert, rec, tec}, 23'h600000)
        nd = 1;
        tick(3);
        `CK(sus, 1'b0)
        idle = 1;
        tick(1);
        `CK({sus, bof, hold}, 3'b101)
        $display("suspend test done");
        idle = 0;
        nd = 0;
        hc = 1;
        tick(1);
        hc = 0;
        mdr = 1;
        tick(1);
        `CK({hold, txd, sus}, 3'b000)
        mdr = 0;
        tq = 1;
        tick(1);
        `CK(txd, 1'b0)
        tq = 0;
        hs = 1;
        tick(1);
        hs = 0;
        mdr = 1;
        tick(1);
        `CK({hold, txd}, 2'b11)
        mdr = 0;
        hc = 1;
        tick(1);
        hc = 0;
        ti = 1;
        tick(12);
        `CK({tec, ewf}, 10'h0c1)
        tick(20);
        ti = 0;
        tick(3);
        `CK({bof, hold, rec, tec}, 20'hc0201)
        $display("bus-off test done");
        idle = 1;
        wait_rec(9'h060);
        `CK({ewf, bof}, 2'b11)
        wait_rec(9'h000);
        `CK({ewf, bof, alert, hold}, 4'b0011)
        `CK(nidle, 128)
        `CK(ts, nbit)
        ac = 1;
        tick(1);
        `CK(alert, 1'b0)
        $display("recovery test done");
        end_of_test;
    end
endmodule // cnec_node_test
`default_nettype wire
